//--- eebm_defs.svh
`ifndef EEBM_DEFS_SVH
`define EEBM_DEFS_SVH
`define EEBM_CLK_NS      40
`define EEBM_T_QTR_NS    2500
`define EEBM_QTR_CYC     (`EEBM_T_QTR_NS / `EEBM_CLK_NS)
`define EEBM_QCNT_W      7
`define EEBM_DIR_BIT     0
`define EEBM_ACK_BIT     4'h8
`define EEBM_LAST_DATA   4'h7
`endif

//--- eebm_master.sv
`timescale 1ns/1ns
`default_nettype none
`include "eebm_defs.svh"
module eebm_master (
  input  wire logic       I_REF_CLK,
  input  wire logic       I_RST_B,
  input  wire logic [7:0] I_SLV_ADDR,
  input  wire logic [7:0] I_TX_DATA,
  input  wire logic       I_TX_WR,
  input  wire logic       I_RX_RD,
  input  wire logic       I_STOP_AFTER_RX,
  input  wire logic       I_STOP_AFTER_TX,
  input  wire logic       I_SDA,
  output logic            O_SDA_O,
  output logic            O_SDA_OE,
  output logic            O_SCL_O,
  output logic            O_SCL_OE,
  output logic [7:0]      O_RX_DATA,
  output logic            O_TX_EMPTY,
  output logic            O_RX_FULL,
  output logic            O_NACK,
  output logic            O_BUSY
);
  localparam logic [`EEBM_QCNT_W-1:0] QTR_LAST = `EEBM_QCNT_W'(`EEBM_QTR_CYC - 1);

  eebm_pkg::eebm_state_t     state_r, state_nxt;
  eebm_pkg::eebm_ctrl_t      ctrl;
  logic [`EEBM_QCNT_W-1:0]   qcnt_r, qcnt_nxt;
  logic [1:0]                ph_r, ph_nxt;
  logic [3:0]                bit_r, bit_nxt;
  logic [7:0]                sh_r, sh_nxt;
  logic [7:0]                txbuf_r, txbuf_nxt;
  logic [7:0]                rxd_r, rxd_nxt;
  logic                      rxmode_r, rxmode_nxt;
  logic                      adrbyte_r, adrbyte_nxt;
  logic                      rdtxn_r, rdtxn_nxt;
  logic                      last_r, last_nxt;
  logic                      sda_drv_r, sda_drv_nxt;
  logic                      scl_low_r, scl_low_nxt;
  logic                      txe_r, txe_nxt;
  logic                      rxf_r, rxf_nxt;
  logic                      nack_r, nack_nxt;
  logic                      sda_m1_r, sda_s_r;
  logic                      tick, byte_end, rx_latch, timed;

  assign ctrl.stop_rx = I_STOP_AFTER_RX;
  assign ctrl.stop_tx = I_STOP_AFTER_TX;
  assign timed    = (state_r == eebm_pkg::ST_START) || (state_r == eebm_pkg::ST_SHIFT) ||
                    (state_r == eebm_pkg::ST_STOP);
  assign tick     = timed && (qcnt_r == QTR_LAST);
  assign byte_end = (state_r == eebm_pkg::ST_SHIFT) && tick && (ph_r == 2'h3) &&
                    (bit_r == `EEBM_ACK_BIT);
  assign rx_latch = (state_r == eebm_pkg::ST_SHIFT) && tick && (ph_r == 2'h3) &&
                    (bit_r == `EEBM_LAST_DATA) && rxmode_r;

  // sda pin synchroniser
  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sda_m1_r <= 1'b1;
      sda_s_r  <= 1'b1;
    end else begin
      sda_m1_r <= I_SDA;
      sda_s_r  <= sda_m1_r;
    end
  end

  always_comb begin
    state_nxt   = state_r;
    qcnt_nxt    = tick ? '0 : (timed ? qcnt_r + `EEBM_QCNT_W'(1) : '0);
    ph_nxt      = tick ? ph_r + 2'h1 : ph_r;
    bit_nxt     = bit_r;
    sh_nxt      = sh_r;
    txbuf_nxt   = txbuf_r;
    rxd_nxt     = rxd_r;
    rxmode_nxt  = rxmode_r;
    adrbyte_nxt = adrbyte_r;
    rdtxn_nxt   = rdtxn_r;
    last_nxt    = last_r;
    sda_drv_nxt = sda_drv_r;
    scl_low_nxt = scl_low_r;
    txe_nxt     = txe_r;
    rxf_nxt     = rxf_r;
    nack_nxt    = nack_r;
    if (I_RX_RD) begin
      rxf_nxt = 1'b0;
    end
    case (state_r)
      eebm_pkg::ST_IDLE: begin
        sda_drv_nxt = 1'b0;
        scl_low_nxt = 1'b0;
        if (I_TX_WR) begin
          txbuf_nxt   = I_TX_DATA;
          txe_nxt     = 1'b0;
          rdtxn_nxt   = I_SLV_ADDR[`EEBM_DIR_BIT];
          if (I_SLV_ADDR[`EEBM_DIR_BIT]) begin
            rxf_nxt = 1'b0;
          end
          state_nxt   = eebm_pkg::ST_START;
          ph_nxt      = 2'h0;
          qcnt_nxt    = '0;
        end
      end
      eebm_pkg::ST_START: begin
        if (tick) begin
          case (ph_r)
            2'h0: scl_low_nxt = 1'b0;
            2'h1: sda_drv_nxt = 1'b1;
            2'h2: scl_low_nxt = 1'b1;
            default: begin
              state_nxt   = eebm_pkg::ST_SHIFT;
              sh_nxt      = I_SLV_ADDR;
              sda_drv_nxt = ~I_SLV_ADDR[7];
              bit_nxt     = 4'h0;
              rxmode_nxt  = 1'b0;
              adrbyte_nxt = 1'b1;
            end
          endcase
        end
      end
      eebm_pkg::ST_SHIFT: begin
        if (tick) begin
          case (ph_r)
            2'h0: scl_low_nxt = 1'b0;
            2'h1: begin
              if (bit_r == `EEBM_ACK_BIT) begin
                if (!rxmode_r) begin
                  nack_nxt = sda_s_r;
                end
              end else begin
                sh_nxt = {sh_r[6:0], sda_s_r};
              end
            end
            2'h2: scl_low_nxt = 1'b1;
            default: begin
              bit_nxt = bit_r + 4'h1;
              if (bit_r == `EEBM_LAST_DATA) begin
                if (rxmode_r) begin
                  rxd_nxt     = sh_r;
                  rxf_nxt     = 1'b1;
                  last_nxt    = ctrl.stop_rx;
                  sda_drv_nxt = ~ctrl.stop_rx;
                end else begin
                  sda_drv_nxt = 1'b0;
                end
              end else if (bit_r == `EEBM_ACK_BIT) begin
                bit_nxt = 4'h0;
                if (adrbyte_r && rdtxn_r) begin
                  adrbyte_nxt = 1'b0;
                  rxmode_nxt  = 1'b1;
                  sda_drv_nxt = 1'b0;
                  txe_nxt     = 1'b1;
                end else if (adrbyte_r) begin
                  adrbyte_nxt = 1'b0;
                  sh_nxt      = txbuf_r;
                  sda_drv_nxt = ~txbuf_r[7];
                end else if (!rxmode_r) begin
                  txe_nxt = 1'b1;
                  if (ctrl.stop_tx) begin
                    state_nxt   = eebm_pkg::ST_STOP;
                    sda_drv_nxt = 1'b1;
                  end else begin
                    state_nxt   = eebm_pkg::ST_HOLD;
                    sda_drv_nxt = 1'b0;
                  end
                end else if (last_r) begin
                  state_nxt   = eebm_pkg::ST_STOP;
                  sda_drv_nxt = 1'b1;
                end else begin
                  state_nxt   = eebm_pkg::ST_RWAIT;
                  sda_drv_nxt = 1'b0;
                end
              end else begin
                sda_drv_nxt = rxmode_r ? 1'b0 : ~sh_r[7];
              end
            end
          endcase
        end
      end
      eebm_pkg::ST_STOP: begin
        if (tick) begin
          case (ph_r)
            2'h0: scl_low_nxt = 1'b0;
            2'h1: sda_drv_nxt = 1'b0;
            2'h2: sda_drv_nxt = 1'b0;
            default: state_nxt = eebm_pkg::ST_IDLE;
          endcase
        end
      end
      eebm_pkg::ST_HOLD: begin
        if (I_TX_WR) begin
          txbuf_nxt = I_TX_DATA;
          txe_nxt   = 1'b0;
          ph_nxt    = 2'h0;
          qcnt_nxt  = '0;
          if (I_SLV_ADDR[`EEBM_DIR_BIT]) begin
            rdtxn_nxt = 1'b1;
            rxf_nxt   = 1'b0;
            state_nxt = eebm_pkg::ST_START;
          end else begin
            state_nxt   = eebm_pkg::ST_SHIFT;
            sh_nxt      = I_TX_DATA;
            sda_drv_nxt = ~I_TX_DATA[7];
            bit_nxt     = 4'h0;
            rxmode_nxt  = 1'b0;
            adrbyte_nxt = 1'b0;
          end
        end
      end
      eebm_pkg::ST_RWAIT: begin
        if (!rxf_r) begin
          state_nxt   = eebm_pkg::ST_SHIFT;
          ph_nxt      = 2'h0;
          qcnt_nxt    = '0;
          bit_nxt     = 4'h0;
          sda_drv_nxt = 1'b0;
        end
      end
      default: state_nxt = eebm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_r   <= eebm_pkg::ST_IDLE;
      qcnt_r    <= '0;
      ph_r      <= 2'h0;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      txbuf_r   <= 8'h00;
      rxd_r     <= 8'h00;
      rxmode_r  <= 1'b0;
      adrbyte_r <= 1'b0;
      rdtxn_r   <= 1'b0;
      last_r    <= 1'b0;
      sda_drv_r <= 1'b0;
      scl_low_r <= 1'b0;
      txe_r     <= 1'b1;
      rxf_r     <= 1'b0;
      nack_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      qcnt_r    <= qcnt_nxt;
      ph_r      <= ph_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      txbuf_r   <= txbuf_nxt;
      rxd_r     <= rxd_nxt;
      rxmode_r  <= rxmode_nxt;
      adrbyte_r <= adrbyte_nxt;
      rdtxn_r   <= rdtxn_nxt;
      last_r    <= last_nxt;
      sda_drv_r <= sda_drv_nxt;
      scl_low_r <= scl_low_nxt;
      txe_r     <= txe_nxt;
      rxf_r     <= rxf_nxt;
      nack_r    <= nack_nxt;
    end
  end

  assign O_SDA_O    = 1'b0;
  assign O_SDA_OE   = sda_drv_r;
  assign O_SCL_O    = 1'b0;
  assign O_SCL_OE   = scl_low_r;
  assign O_RX_DATA  = rxd_r;
  assign O_TX_EMPTY = txe_r;
  assign O_RX_FULL  = rxf_r;
  assign O_NACK     = nack_r;
  assign O_BUSY     = (state_r != eebm_pkg::ST_IDLE);

  a_idle_start: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (state_r == eebm_pkg::ST_IDLE) && I_TX_WR |=> (state_r == eebm_pkg::ST_START)
    ##[1:300] (state_r == eebm_pkg::ST_SHIFT) && adrbyte_r)
    else $error("write from idle did not start with address");
  a_txe_busy: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    I_TX_WR && ((state_r == eebm_pkg::ST_IDLE) || (state_r == eebm_pkg::ST_HOLD))
    |=> !O_TX_EMPTY)
    else $error("transmit write left empty flag set");
  a_rxf_launch: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    I_TX_WR && I_SLV_ADDR[0] && (state_r == eebm_pkg::ST_IDLE) |=> !O_RX_FULL)
    else $error("read launch did not clear receiver full");
  a_rxf_clear: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    I_RX_RD && !rx_latch |=> !O_RX_FULL)
    else $error("receive read did not clear receiver full");
  a_rx_load: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    rx_latch |=> O_RX_FULL && (O_RX_DATA == $past(sh_r)))
    else $error("received byte not loaded");
  a_tx_done: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    byte_end && !rxmode_r && !adrbyte_r |=> O_TX_EMPTY)
    else $error("sent byte did not set empty flag");
  a_tx_stop: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    byte_end && !rxmode_r && !adrbyte_r && ctrl.stop_tx |=> (state_r == eebm_pkg::ST_STOP))
    else $error("transmit stop not generated");
  a_tx_open: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    byte_end && !rxmode_r && !adrbyte_r && !ctrl.stop_tx |=> (state_r == eebm_pkg::ST_HOLD))
    else $error("bus not held open after byte");
  a_rx_stop: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    byte_end && rxmode_r |=> (state_r == ($past(last_r) ? eebm_pkg::ST_STOP
                                                        : eebm_pkg::ST_RWAIT)))
    else $error("wrong end after received byte");
  a_hold_shift: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (state_r == eebm_pkg::ST_HOLD) && I_TX_WR && !I_SLV_ADDR[0]
    |=> (state_r == eebm_pkg::ST_SHIFT) && !adrbyte_r && (sh_r == $past(I_TX_DATA)))
    else $error("open transaction write not shifted alone");
  a_addr_data: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    byte_end && adrbyte_r && !rdtxn_r |=> (state_r == eebm_pkg::ST_SHIFT) &&
    (sh_r == txbuf_r) && !adrbyte_r)
    else $error("data byte did not follow address");
  a_master_ack: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    rx_latch |=> (O_SDA_OE == !last_r) [*8])
    else $error("master ack level wrong");
  a_rx_next: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (state_r == eebm_pkg::ST_RWAIT) && !O_RX_FULL |=> (state_r == eebm_pkg::ST_SHIFT))
    else $error("next byte not received after read");
endmodule // eebm_master
`default_nettype wire

//--- eebm_pkg.sv
package eebm_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_START = 6'h02,
    ST_SHIFT = 6'h04,
    ST_STOP  = 6'h08,
    ST_HOLD  = 6'h10,
    ST_RWAIT = 6'h20
  } eebm_state_t;

  typedef struct packed {
    logic stop_rx;
    logic stop_tx;
  } eebm_ctrl_t;
endpackage

//--- eebm_rom_model.sv
`timescale 1ns/1ns
`default_nettype none
module eebm_rom_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var  logic o_sda_oe
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic       rd;
  int         bn;
  int         un;
  initial begin
    o_sda_oe = 1'b0;
    rd = 1'b0;
    bn = 0;
    un = -1;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // start and stop on the wire; the start's own scl fall ends no bit
  always @(negedge i_sda) if (i_scl) begin
    bn = -1;
    un = 0;
  end
  always @(posedge i_sda) if (i_scl) un = -1;
  // shift in; master nack ends a read
  always @(posedge i_scl) if (un >= 0) begin
    if (bn < 8) sh = {sh[6:0], i_sda};
    else if (rd && un > 0 && i_sda) un = -1;
  end
  // drive ack or read bits while scl low
  always @(negedge i_scl) if (un >= 0) begin
    bn++;
    if (bn == 9) begin
      bn = 0;
      un++;
    end
    if (rd && un > 0) o_sda_oe = (bn < 8) ? ~mem[ptr][7-bn] : 1'b0;
    else o_sda_oe = (bn == 8);
    if (bn == 8) begin
      if (un == 0) rd = sh[0];
      else if (rd) ptr++;
      else if (un == 2) ptr = sh;
      else if (un > 2) begin
        mem[ptr] = sh;
        ptr++;
      end
    end
  end
endmodule // eebm_rom_model
`default_nettype wire

//--- eebm_tb.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] slv = 8'h00;
  logic [7:0] txd = 8'h00;
  logic       tx_wr = 1'b0;
  logic       rx_rd = 1'b0;
  logic       stp_rx = 1'b0;
  logic       stp_tx = 1'b0;
  logic       sda_oe, scl_oe, m_oe, tx_empty, rx_full, nack, busy;
  logic       sda_o, scl_o;
  logic [7:0] rxd;
  wire        sda = ~(sda_oe | m_oe);
  wire        scl = ~scl_oe;
  int         miscompares = 0;
  int         checks_done = 0;
  int         starts = 0;
  int         stops = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  eebm_master dut_u (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_SLV_ADDR(slv), .I_TX_DATA(txd),
    .I_TX_WR(tx_wr), .I_RX_RD(rx_rd), .I_STOP_AFTER_RX(stp_rx), .I_STOP_AFTER_TX(stp_tx),
    .I_SDA(sda), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .O_SCL_O(scl_o), .O_SCL_OE(scl_oe),
    .O_RX_DATA(rxd), .O_TX_EMPTY(tx_empty), .O_RX_FULL(rx_full), .O_NACK(nack),
    .O_BUSY(busy));
  eebm_rom_model slave_u (.i_scl(scl), .i_sda(sda), .o_sda_oe(m_oe));
  always @(negedge sda) if (scl === 1'b1) starts++;
  always @(posedge sda) if (scl === 1'b1) stops++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // wait: 0 tx empty, 1 rx full, 2 idle
  task automatic wt(input int k);
    int   n;
    logic f;
    n = 0;
    f = 1'b0;
    while (!f && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      f = (k == 0) ? tx_empty === 1'b1 : (k == 1) ? rx_full === 1'b1 : busy === 1'b0;
    end
    chk(8'(f), 8'h1);
  endtask
  task automatic wr(input logic [7:0] d);
    txd = d;
    tx_wr = 1'b1;
    @(posedge clk);
    #1;
    tx_wr = 1'b0;
    @(posedge clk);
    #1;
    chk(8'(tx_empty), 8'h0);
    wt(0);
  endtask
  task automatic rdp;
    rx_rd = 1'b1;
    @(posedge clk);
    #1;
    rx_rd = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic t_write(input logic [7:0] a, input int n);
    int s0;
    int b0;
    s0 = stops;
    b0 = starts;
    stp_tx = 1'b0;
    slv = 8'ha0;
    wr(8'h00);
    chk(8'(busy), 8'h1);
    wr(a);
    for (int i = 0; i < n; i++) begin
      chk(8'(stops - s0), 8'h0);
      if (i == n - 1) stp_tx = 1'b1;
      wr(8'h3c + 8'(i));
    end
    wt(2);
    chk(8'(stops - s0), 8'h1);
    chk(8'(starts - b0), 8'h1);
    chk(8'(nack), 8'h0);
    for (int i = 0; i < n; i++) chk(slave_u.mem[a + 8'(i)], 8'h3c + 8'(i));
  endtask
  task automatic t_read(input logic [7:0] a, input int n);
    int s0;
    int b0;
    s0 = stops;
    b0 = starts;
    stp_tx = 1'b0;
    stp_rx = (n == 1);
    slv = 8'ha0;
    wr(8'h00);
    wr(a);
    slv = 8'ha1;
    wr(8'hff);
    chk(8'(rx_full), 8'h0);
    for (int i = 0; i < n; i++) begin
      wt(1);
      chk(rxd, slave_u.mem[a + 8'(i)]);
      if (i == n - 1) break;
      chk(8'(stops - s0), 8'h0);
      if (i == n - 2) stp_rx = 1'b1;
      rdp;
      chk(8'(rx_full), 8'h0);
    end
    wt(2);
    chk(8'(stops - s0), 8'h1);
    chk(8'(starts - b0), 8'h2);
  endtask
  task automatic t_cur(input logic [7:0] a);
    int s0;
    int b0;
    s0 = stops;
    b0 = starts;
    stp_rx = 1'b1;
    slv = 8'ha1;
    wr(8'hff);
    chk(8'(rx_full), 8'h0);
    wt(1);
    chk(rxd, slave_u.mem[a]);
    wt(2);
    chk(8'(stops - s0), 8'h1);
    chk(8'(starts - b0), 8'h1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'b1;
    chk({2'h0, sda_o, scl_o, tx_empty, rx_full, busy, scl_oe}, 8'h08);
    t_write(8'h10, 1);
    t_write(8'h60, 3);
    t_read(8'h20, 1);
    t_read(8'h40, 4);
    t_cur(8'h44);
    results;
  end
  initial begin
    #3000000;
    miscompares++;
    results;
  end
endmodule // testbench
`default_nettype wire
